//--- src/rlcsr_regs.sv
// Retry limits and compare-swap register bank with bus-management resources
//
// Contract
// - Retry limits bits 31-29 (dual-phase seconds) read as zero.
// - Retry limits bits 28-16 (dual-phase cycles) read as zero.
// - Retry limits reserved bits 15-12 read as zero.
// - Bits 11-8 hold the writable physical response retry limit.
// - Bits 7-4 hold the writable async transmit response retry limit.
// - Bits 3-0 hold the writable async transmit request retry limit.
// - New-value register supplies data stored when the compare succeeds.
// - Expected-value register is compared with the selected resource.
// - Swap done bit 31 of swap control sets when a swap finishes.
// - Every write to swap control clears the done bit, except one in the cycle a swap completes.
// - Swap control reserved bits 30-2 read as zero.
// - Select 00 manager ID, 01 bandwidth, 10 channels high, 11 channels low.
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module rlcsr_regs #(
    parameter int unsigned RETRY_W = 4
) (
    input  wire logic        clock_in,
    input  wire logic        reset_n_in,
    // Register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rd_data_out,
    // Retry limits toward the transmit units
    output logic      [3:0]  phys_response_retry_limit_out,
    output logic      [3:0]  async_response_retry_limit_out,
    output logic      [3:0]  async_request_retry_limit_out,
    // Bus-management resources
    output logic      [31:0] bus_manager_id_out,
    output logic      [31:0] bandwidth_available_out,
    output logic      [31:0] channels_available_hi_out,
    output logic      [31:0] channels_available_lo_out,
    // Status
    output logic             swap_done_out,
    output logic             irq_out
);
    initial begin
        if (RETRY_W != rlcsr_pkg::RETRY_W) begin
            $error("rlcsr_regs: RETRY_W must match the field width");
        end
    end

    typedef struct packed {
        logic [3:0]             phys_retry;
        logic [3:0]             rsp_retry;
        logic [3:0]             req_retry;
        logic [31:0]            new_value;
        logic [31:0]            expected_value;
        logic [1:0]             resource_select;
        logic                   swap_done;
        logic [1:0]             active_select;
        logic [31:0]            old_value;
        rlcsr_pkg::rlcsr_state_t state;
        logic [31:0]            rd_data;
    } rlcsr_regs_t;

    rlcsr_regs_t s_q;
    rlcsr_regs_t s_d;

    // Datapath to submodules
    logic                                 store_wr;
    logic [31:0]                          store_rd;
    logic [rlcsr_pkg::NUM_RESOURCES-1:0][31:0] store_words;
    logic [rlcsr_pkg::NUM_EVENTS-1:0]     events;
    logic [rlcsr_pkg::NUM_EVENTS-1:0]     irq_status;
    logic [rlcsr_pkg::NUM_EVENTS-1:0]     irq_mask;
    logic                                 irq_status_wr;
    logic                                 irq_mask_wr;
    logic [31:0]                          retry_word;
    logic [31:0]                          ctrl_word;
    logic [31:0]                          read_mux;
    logic                                 swap_match;

    // Register images as software sees them
    always_comb begin
        retry_word = rlcsr_pkg::WORD_ZERO;
        retry_word[rlcsr_pkg::PHYS_RSP_LSB +: rlcsr_pkg::RETRY_W]  = s_q.phys_retry;
        retry_word[rlcsr_pkg::ASYNC_RSP_LSB +: rlcsr_pkg::RETRY_W] = s_q.rsp_retry;
        retry_word[rlcsr_pkg::ASYNC_REQ_LSB +: rlcsr_pkg::RETRY_W] = s_q.req_retry;
        // Bits above the three limits stay zero, and
        ctrl_word = rlcsr_pkg::WORD_ZERO;
        ctrl_word[rlcsr_pkg::DONE_BIT] = s_q.swap_done;
        ctrl_word[rlcsr_pkg::SEL_LSB +: rlcsr_pkg::SEL_W] = s_q.resource_select;
    end

    always_comb begin
        unique case (addr_in)
            rlcsr_pkg::OFS_RETRY_LIMITS: begin
                read_mux = retry_word;
            end
            rlcsr_pkg::OFS_SWAP_NEW: begin
                read_mux = s_q.new_value;
            end
            rlcsr_pkg::OFS_SWAP_EXP: begin
                read_mux = s_q.expected_value;
            end
            rlcsr_pkg::OFS_SWAP_CTRL: begin
                read_mux = ctrl_word;
            end
            rlcsr_pkg::OFS_IRQ_STATUS: begin
                read_mux = {30'h0000_0000, irq_status};
            end
            rlcsr_pkg::OFS_IRQ_MASK: begin
                read_mux = {30'h0000_0000, irq_mask};
            end
            rlcsr_pkg::OFS_SWAP_OLD: begin
                read_mux = s_q.old_value;
            end
            default: begin
                read_mux = rlcsr_pkg::WORD_ZERO;
            end
        endcase
    end

    assign swap_match    = (s_q.old_value == s_q.expected_value);
    assign irq_status_wr = wr_in && (addr_in == rlcsr_pkg::OFS_IRQ_STATUS);
    assign irq_mask_wr   = wr_in && (addr_in == rlcsr_pkg::OFS_IRQ_MASK);

    always_comb begin
        s_d      = s_q;
        store_wr = 1'b0;
        events   = rlcsr_pkg::EVENTS_RESET;

        // Read data stands only in the cycle after the strobe
        s_d.rd_data = rd_in ? read_mux : rlcsr_pkg::WORD_ZERO;

        if (wr_in) begin
            unique case (addr_in)
                rlcsr_pkg::OFS_RETRY_LIMITS: begin
                    s_d.phys_retry = wr_data_in[rlcsr_pkg::PHYS_RSP_LSB +: rlcsr_pkg::RETRY_W];
                    s_d.rsp_retry  = wr_data_in[rlcsr_pkg::ASYNC_RSP_LSB +: rlcsr_pkg::RETRY_W];
                    s_d.req_retry  = wr_data_in[rlcsr_pkg::ASYNC_REQ_LSB +: rlcsr_pkg::RETRY_W];
                end
                rlcsr_pkg::OFS_SWAP_NEW: begin
                    s_d.new_value = wr_data_in;
                end
                rlcsr_pkg::OFS_SWAP_EXP: begin
                    s_d.expected_value = wr_data_in;
                end
                rlcsr_pkg::OFS_SWAP_CTRL: begin
                    s_d.resource_select = wr_data_in[rlcsr_pkg::SEL_LSB +: rlcsr_pkg::SEL_W];
                    s_d.swap_done = 1'b0;
                end
                default: begin
                end
            endcase
        end

        unique case (s_q.state)
            rlcsr_pkg::RLCSR_IDLE: begin
                // A write while a swap runs updates select only
                if (wr_in && addr_in == rlcsr_pkg::OFS_SWAP_CTRL) begin
                    s_d.active_select = wr_data_in[rlcsr_pkg::SEL_LSB +: rlcsr_pkg::SEL_W];
                    s_d.state = rlcsr_pkg::RLCSR_FETCH;
                end
            end
            rlcsr_pkg::RLCSR_FETCH: begin
                s_d.old_value = store_rd;
                s_d.state = rlcsr_pkg::RLCSR_SWAP;
            end
            rlcsr_pkg::RLCSR_SWAP: begin
                store_wr = swap_match;
                events[rlcsr_pkg::EV_SWAP_DONE] = 1'b1;
                events[rlcsr_pkg::EV_SWAP_MISS] = ~swap_match;
                // Completion beats a same-cycle control write
                s_d.swap_done = 1'b1;
                s_d.state = rlcsr_pkg::RLCSR_IDLE;
            end
            default: begin
                s_d.state = rlcsr_pkg::RLCSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '{
                phys_retry:      rlcsr_pkg::RETRY_RESET,
                rsp_retry:       rlcsr_pkg::RETRY_RESET,
                req_retry:       rlcsr_pkg::RETRY_RESET,
                new_value:       rlcsr_pkg::WORD_ZERO,
                expected_value:  rlcsr_pkg::WORD_ZERO,
                resource_select: rlcsr_pkg::SEL_RESET,
                swap_done:       rlcsr_pkg::DONE_RESET,
                active_select:   rlcsr_pkg::SEL_RESET,
                old_value:       rlcsr_pkg::WORD_ZERO,
                state:           rlcsr_pkg::RLCSR_IDLE,
                rd_data:         rlcsr_pkg::WORD_ZERO
            };
        end else begin
            s_q <= s_d;
        end
    end

    rlcsr_res_store #(
        .NUM (rlcsr_pkg::NUM_RESOURCES),
        .W   (rlcsr_pkg::DATA_W)
    ) u_store (
        .clock_in    (clock_in),
        .reset_n_in  (reset_n_in),
        .wr_en_in    (store_wr),
        .wr_sel_in   (s_q.active_select),
        .wr_data_in  (s_q.new_value),
        .rd_sel_in   (s_q.active_select),
        .rd_data_out (store_rd),
        .words_out   (store_words)
    );

    rlcsr_irq #(
        .N (rlcsr_pkg::NUM_EVENTS)
    ) u_irq (
        .clock_in     (clock_in),
        .reset_n_in   (reset_n_in),
        .event_in     (events),
        .status_wr_in (irq_status_wr),
        .mask_wr_in   (irq_mask_wr),
        .wr_data_in   (wr_data_in[rlcsr_pkg::NUM_EVENTS-1:0]),
        .status_out   (irq_status),
        .mask_out     (irq_mask),
        .irq_out      (irq_out)
    );

    assign rd_data_out                    = s_q.rd_data;
    assign phys_response_retry_limit_out  = s_q.phys_retry;
    assign async_response_retry_limit_out = s_q.rsp_retry;
    assign async_request_retry_limit_out  = s_q.req_retry;
    assign swap_done_out                  = s_q.swap_done;
    assign bus_manager_id_out        = store_words[rlcsr_pkg::SEL_BUS_MANAGER_ID];
    assign bandwidth_available_out   = store_words[rlcsr_pkg::SEL_BANDWIDTH_AVAIL];
    assign channels_available_hi_out = store_words[rlcsr_pkg::SEL_CHANNELS_AVAIL_H];
    assign channels_available_lo_out = store_words[rlcsr_pkg::SEL_CHANNELS_AVAIL_L];
endmodule

//--- src/rlcsr_pkg.sv
// Package: offsets, field layout, reset values and states of the retry/compare-swap bank
package rlcsr_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_RETRY_LIMITS = 8'h08;
    localparam logic [7:0] OFS_SWAP_NEW     = 8'h0C;
    localparam logic [7:0] OFS_SWAP_EXP     = 8'h10;
    localparam logic [7:0] OFS_SWAP_CTRL    = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'h40;
    localparam logic [7:0] OFS_IRQ_MASK     = 8'h44;
    localparam logic [7:0] OFS_SWAP_OLD     = 8'h48;

    // Retry limits field layout
    localparam int unsigned RETRY_W       = 4;
    localparam int unsigned ASYNC_REQ_LSB = 0;
    localparam int unsigned ASYNC_RSP_LSB = 4;
    localparam int unsigned PHYS_RSP_LSB  = 8;
    localparam logic [3:0]  RETRY_RESET   = 4'h0;

    // Swap control field layout
    localparam int unsigned SEL_W          = 2;
    localparam int unsigned SEL_LSB        = 0;
    localparam int unsigned DONE_BIT       = 31;
    localparam logic        DONE_RESET     = 1'b1;
    localparam logic [1:0]  SEL_RESET      = 2'h0;

    // Resource select codes
    localparam logic [1:0] SEL_BUS_MANAGER_ID   = 2'h0;
    localparam logic [1:0] SEL_BANDWIDTH_AVAIL  = 2'h1;
    localparam logic [1:0] SEL_CHANNELS_AVAIL_H = 2'h2;
    localparam logic [1:0] SEL_CHANNELS_AVAIL_L = 2'h3;
    localparam int unsigned NUM_RESOURCES       = 4;

    // Resource reset values
    localparam logic [31:0] RES_RESET = 32'h0000_0000;

    // Interrupt event bits
    localparam int unsigned NUM_EVENTS     = 2;
    localparam int unsigned EV_SWAP_DONE   = 0;
    localparam int unsigned EV_SWAP_MISS   = 1;
    localparam logic [1:0]  EVENTS_RESET   = 2'h0;

    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        RLCSR_IDLE  = 3'b001,
        RLCSR_FETCH = 3'b010,
        RLCSR_SWAP  = 3'b100
    } rlcsr_state_t;

endpackage

//--- src/rlcsr_res_store.sv
// Four bus-management resources with a single compare-swap write port
`timescale 1ns/10ps
module rlcsr_res_store #(
    parameter int unsigned NUM = 4,
    parameter int unsigned W   = 32
) (
    input  wire logic                   clock_in,
    input  wire logic                   reset_n_in,
    input  wire logic                   wr_en_in,
    input  wire logic [1:0]             wr_sel_in,
    input  wire logic [W-1:0]           wr_data_in,
    input  wire logic [1:0]             rd_sel_in,
    output logic      [W-1:0]           rd_data_out,
    output logic      [NUM-1:0][W-1:0]  words_out
);
    initial begin
        if (NUM != rlcsr_pkg::NUM_RESOURCES || W != rlcsr_pkg::DATA_W) begin
            $error("rlcsr_res_store: unsupported NUM or W");
        end
    end

    typedef struct packed {
        logic [NUM-1:0][W-1:0] words;
    } rlcsr_store_t;

    rlcsr_store_t s_q;
    rlcsr_store_t s_d;

    always_comb begin
        s_d = s_q;
        if (wr_en_in) begin
            s_d.words[wr_sel_in] = wr_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '{words: {NUM{rlcsr_pkg::RES_RESET}}};
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data_out = s_q.words[rd_sel_in];
    assign words_out   = s_q.words;
endmodule

//--- src/rlcsr_irq.sv
// Sticky event status, write-one-to-clear, with mask and level interrupt
`timescale 1ns/10ps
module rlcsr_irq #(
    parameter int unsigned N = 2
) (
    input  wire logic         clock_in,
    input  wire logic         reset_n_in,
    input  wire logic [N-1:0] event_in,
    input  wire logic         status_wr_in,
    input  wire logic         mask_wr_in,
    input  wire logic [N-1:0] wr_data_in,
    output logic      [N-1:0] status_out,
    output logic      [N-1:0] mask_out,
    output logic              irq_out
);
    initial begin
        if (N != rlcsr_pkg::NUM_EVENTS) begin
            $error("rlcsr_irq: unsupported N");
        end
    end

    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] mask;
        logic         irq;
    } rlcsr_irq_t;

    rlcsr_irq_t s_q;
    rlcsr_irq_t s_d;

    always_comb begin
        s_d = s_q;
        // Set wins over a clear in the same cycle
        if (status_wr_in) begin
            s_d.status = s_q.status & ~wr_data_in;
        end
        s_d.status = s_d.status | event_in;
        if (mask_wr_in) begin
            s_d.mask = wr_data_in;
        end
        s_d.irq = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '{status: rlcsr_pkg::EVENTS_RESET, mask: rlcsr_pkg::EVENTS_RESET, irq: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign status_out = s_q.status;
    assign mask_out   = s_q.mask;
    assign irq_out    = s_q.irq;
endmodule

//--- tb/rlcsr_regs_properties.sv
// Port-level checks for the retry limits and compare-swap register bank
`timescale 1ns/10ps
module rlcsr_regs_properties #(
    parameter int unsigned RETRY_W = 4
) (
    input wire logic        clock_in,
    input wire logic        reset_n_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rd_data_out,
    input wire logic [3:0]  phys_response_retry_limit_out,
    input wire logic [3:0]  async_response_retry_limit_out,
    input wire logic [3:0]  async_request_retry_limit_out,
    input wire logic [31:0] bus_manager_id_out,
    input wire logic [31:0] bandwidth_available_out,
    input wire logic [31:0] channels_available_hi_out,
    input wire logic [31:0] channels_available_lo_out,
    input wire logic        swap_done_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    logic        rd_ret;
    logic        rd_ctl;
    logic        wr_ret;
    logic        wr_go;
    logic [11:0] lim;
    assign rd_ret = rd_in && addr_in == rlcsr_pkg::OFS_RETRY_LIMITS;
    assign rd_ctl = rd_in && addr_in == rlcsr_pkg::OFS_SWAP_CTRL;
    assign wr_ret = wr_in && addr_in == rlcsr_pkg::OFS_RETRY_LIMITS;
    // Control write while idle starts a swap
    assign wr_go = wr_in && addr_in == rlcsr_pkg::OFS_SWAP_CTRL && swap_done_out;
    assign lim = {phys_response_retry_limit_out, async_response_retry_limit_out,
                  async_request_retry_limit_out};

    a_retry_upper_zero: assert property (rd_ret |=> rd_data_out[31:12] == 20'h0)
        else $error("retry limits upper bits not zero");
    a_retry_field_write: assert property (wr_ret |=> lim == $past(wr_data_in[11:0]))
        else $error("retry limit fields not loaded");
    a_retry_field_hold: assert property (!wr_ret |=> $stable(lim))
        else $error("retry limit fields changed without write");
    a_ctrl_rsvd_zero: assert property (rd_ctl |=> rd_data_out[30:2] == 29'h0)
        else $error("swap control reserved bits not zero");
    a_ctrl_done_read: assert property (rd_ctl |=> rd_data_out[31] == $past(swap_done_out))
        else $error("swap control done bit misread");
    a_rdata_idle_zero: assert property (!rd_in |=> rd_data_out == 32'h0)
        else $error("read data not zero outside read cycle");
    a_write_clears_done: assert property (wr_go |=> !swap_done_out ##1 !swap_done_out)
        else $error("done not cleared by control write");
    a_swap_finish_time: assert property (wr_go |-> ##3 swap_done_out)
        else $error("swap did not finish in three cycles");
    a_select_isolates: assert property ((wr_go && wr_data_in[1:0] == 2'h1)
        |-> ##1 $stable(bus_manager_id_out) [*3])
        else $error("unselected resource changed");
    // Completion edge excluded: done rises in the cycle the swap writes the resource
    a_resources_idle: assert property ((reset_n_in && swap_done_out
        && $past(swap_done_out)) |-> $stable({bus_manager_id_out, bandwidth_available_out,
                     channels_available_hi_out, channels_available_lo_out}))
        else $error("resource changed while no swap finished");

    c_swap_run: cover property (wr_go ##3 swap_done_out);
    c_ctrl_read: cover property (rd_ctl ##1 rd_data_out[31]);
    c_irq_rise: cover property ($rose(irq_out));
endmodule

bind rlcsr_regs rlcsr_regs_properties #(.RETRY_W(RETRY_W)) u_props (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .phys_response_retry_limit_out(phys_response_retry_limit_out),
    .async_response_retry_limit_out(async_response_retry_limit_out),
    .async_request_retry_limit_out(async_request_retry_limit_out),
    .bus_manager_id_out(bus_manager_id_out), .bandwidth_available_out(bandwidth_available_out),
    .channels_available_hi_out(channels_available_hi_out),
    .channels_available_lo_out(channels_available_lo_out),
    .swap_done_out(swap_done_out), .irq_out(irq_out));

//--- tb/rlcsr_regs_tb.sv
// Self-checking bench for the retry limits and compare-swap register bank
`timescale 1ns/10ps
module rlcsr_regs_tb;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} rlcsr_row_t;
    logic        clock_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [31:0] wr_data_in = 32'h0;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [31:0] rd_data_out;
    logic [3:0]  phys_r;
    logic [3:0]  resp_r;
    logic [3:0]  req_r;
    logic [31:0] res_bm;
    logic [31:0] res_bw;
    logic [31:0] res_hi;
    logic [31:0] res_lo;
    logic [31:0] res [4];
    logic        swap_done_out;
    logic        irq_out;
    int          errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    rlcsr_row_t  rows [6] = '{
        '{rlcsr_pkg::OFS_RETRY_LIMITS, 32'hFFFFFFFF, 32'h00000FFF},
        '{rlcsr_pkg::OFS_RETRY_LIMITS, 32'h00000A5C, 32'h00000A5C},
        '{rlcsr_pkg::OFS_SWAP_NEW, 32'h12345678, 32'h12345678},
        '{rlcsr_pkg::OFS_SWAP_EXP, 32'h9ABCDEF0, 32'h9ABCDEF0},
        '{8'h20, 32'hFFFFFFFF, 32'h00000000},
        '{rlcsr_pkg::OFS_SWAP_OLD, 32'hFFFFFFFF, 32'h00000000}};

    always #25 clock_in = ~clock_in;

    always_comb begin
        res[0] = res_bm;
        res[1] = res_bw;
        res[2] = res_hi;
        res[3] = res_lo;
    end

    rlcsr_regs #(.RETRY_W(4)) dut_u (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
        .phys_response_retry_limit_out(phys_r), .async_response_retry_limit_out(resp_r),
        .async_request_retry_limit_out(req_r), .bus_manager_id_out(res_bm),
        .bandwidth_available_out(res_bw), .channels_available_hi_out(res_hi),
        .channels_available_lo_out(res_lo), .swap_done_out(swap_done_out), .irq_out(irq_out));

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clock_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 chk(nm, e, rd_data_out);
    endtask

    task automatic wait_done();
        for (int i = 0; i < 10 && swap_done_out !== 1'b1; i++) begin
            @(posedge clock_in);
            #1;
        end
        chk("swap_done", 32'h1, {31'h0, swap_done_out});
    endtask

    task automatic swap(input logic [1:0] s, input logic [31:0] x, input logic [31:0] n);
        wr(rlcsr_pkg::OFS_SWAP_NEW, n);
        wr(rlcsr_pkg::OFS_SWAP_EXP, x);
        // Reserved and done bits written as ones must not stick
        wr(rlcsr_pkg::OFS_SWAP_CTRL, {30'h3FFF_FFFF, s});
        #1 chk("done_clear", 32'h0, {31'h0, swap_done_out});
        wait_done();
    endtask

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 1000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        repeat (2) @(posedge clock_in);
        reset_n_in <= 1'b1;
        rd(rlcsr_pkg::OFS_SWAP_CTRL, 32'h80000000, "ctrl_reset");
        rd(rlcsr_pkg::OFS_RETRY_LIMITS, 32'h0, "retry_reset");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e, "row_read");
            if (rows[i].a == rlcsr_pkg::OFS_RETRY_LIMITS) begin
                chk("retry_out", rows[i].e, {20'h0, phys_r, resp_r, req_r});
            end
        end
        $display("test table done");
        for (int s = 0; s < 4; s++) begin
            swap(2'(s), 32'h0, 32'hC0DE0010 + 32'(s));
            chk("res_new", 32'hC0DE0010 + 32'(s), res[s]);
            rd(rlcsr_pkg::OFS_SWAP_CTRL, 32'h80000000 | 32'(s), "ctrl_sel");
        end
        $display("test swap done");
        chk("irq_masked", 32'h0, {31'h0, irq_out});
        rd(rlcsr_pkg::OFS_IRQ_STATUS, 32'h1, "status_done");
        wr(rlcsr_pkg::OFS_IRQ_MASK, 32'h2);
        wr(rlcsr_pkg::OFS_IRQ_STATUS, 32'h1);
        swap(2'h1, 32'h5, 32'hDEAD0001);
        chk("res_kept", 32'hC0DE0011, res[1]);
        chk("irq_miss", 32'h1, {31'h0, irq_out});
        rd(rlcsr_pkg::OFS_IRQ_STATUS, 32'h3, "status_miss");
        wr(rlcsr_pkg::OFS_IRQ_STATUS, 32'h3);
        #1 chk("irq_clear", 32'h0, {31'h0, irq_out});
        $display("test irq done");
        // Second control write lands while the swap runs
        wr(rlcsr_pkg::OFS_SWAP_NEW, 32'h00000077);
        wr(rlcsr_pkg::OFS_SWAP_EXP, 32'hC0DE0012);
        wr(rlcsr_pkg::OFS_SWAP_CTRL, 32'h2);
        wr(rlcsr_pkg::OFS_SWAP_CTRL, 32'h3);
        repeat (4) @(posedge clock_in);
        #1 chk("res_swap", 32'h00000077, res[2]);
        chk("res_other", 32'hC0DE0013, res[3]);
        rd(rlcsr_pkg::OFS_SWAP_CTRL, 32'h80000003, "ctrl_busy");
        $display("test busy done");
        wr(rlcsr_pkg::OFS_RETRY_LIMITS, 32'h000005A5);
        reset_n_in <= 1'b0;
        @(posedge clock_in);
        reset_n_in <= 1'b1;
        #1 chk("retry_rst", 32'h0, {20'h0, phys_r, resp_r, req_r});
        chk("done_rst", 32'h1, {31'h0, swap_done_out});
        chk("res_rst", 32'h0, res[2]);
        $display("test reset done");
        summarize();
    end
endmodule
